//--- shared/adc_ctrl_pkg.sv
/*
  Constants, register map and state types for the converter control block.
  Assumes a 50 MHz pclk; printed offsets are word indices, byte address is four times the index.
*/
package adc_ctrl_pkg;
  localparam int RES_W = 10;
  localparam int NCH   = 16;
  localparam int CH_W  = 4;
  localparam int CNT_W = 8;
  localparam int IRQ_W = 3;

  // Register word indices
  localparam logic [31:0] IDX_MODE_SEL = 32'hFFFFF319;
  localparam logic [31:0] IDX_PRIO     = 32'hFFFFF31A;
  localparam logic [31:0] IDX_RES0     = 32'hFFFFF340;
  localparam logic [31:0] IDX_PRES     = 32'hFFFFF350;
  localparam logic [31:0] IDX_CTRL     = 32'hFFFFF351;
  localparam logic [31:0] IDX_MON      = 32'hFFFFF352;
  localparam logic [31:0] IDX_CMPV     = 32'hFFFFF353;
  localparam logic [31:0] IDX_ISTAT    = 32'hFFFFF354;
  localparam logic [31:0] IDX_IMASK    = 32'hFFFFF355;

  // Field positions
  localparam int MS_IDLE_BIT    = 6;
  localparam int MS_WIDTH_BIT   = 4;
  localparam int PR_END_BIT     = 7;
  localparam int PR_BUSY_BIT    = 6;
  localparam int PR_START_BIT   = 4;
  localparam int CTRL_SCAN_BIT  = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_REP_BIT   = 2;
  localparam int CTRL_RUN_BIT   = 3;
  localparam int MON_EN_BIT     = 0;
  localparam int MON_SEL_LSB    = 1;
  localparam int MON_GT_BIT     = 7;
  localparam int RES_STORED_BIT = 31;
  localparam int RES_OVR_BIT    = 30;
  localparam int IRQ_NORM       = 0;
  localparam int IRQ_PRIO       = 1;
  localparam int IRQ_MON        = 2;

  // Reset values
  localparam logic [7:0] MODE_SEL_RST = 8'h00;
  localparam logic [7:0] PRIO_RST     = 8'h00;

  // Timing
  localparam int CLK_NS     = 20;
  localparam int SAMPLE_NS  = 400;
  localparam int SETTLE_NS  = 100;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {ENG_IDLE, ENG_SAMPLE, ENG_BIT} eng_state_t;
endpackage

//--- shared/conv_if.sv
/*
  Request and answer signals between the control logic and the conversion engine.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface conv_if import adc_ctrl_pkg::*; ();
  logic             start;
  logic             abort;
  logic             hold;
  logic [CH_W-1:0]  chan;
  logic             busy;
  logic             done;
  logic [RES_W-1:0] result;

  modport ctrl (output start, abort, hold, chan, input busy, done, result);
  modport eng  (input start, abort, hold, chan, output busy, done, result);
endinterface

//--- sim/adc_channel_select_priority_ctrl_tb.sv
/* Self-checking bench for the converter control block.
   Assumes APB answers in its own time; comparator modelled from dac_code per channel. */
`timescale 1ns/1ps
module adc_channel_select_priority_ctrl_tb
  import adc_ctrl_pkg::*;
;
  logic             pclk     = 1'b0;
  logic             presetn  = 1'b0;
  logic [11:0]      paddr    = 12'h000;
  logic             psel     = 1'b0;
  logic             penable  = 1'b0;
  logic             pwrite   = 1'b0;
  logic [31:0]      pwdata   = 32'h0;
  logic [3:0]       pstrb    = 4'hF;
  logic             cpu_idle = 1'b0;
  logic             comp_in  = 1'b0;
  logic [31:0]      prdata;
  logic [31:0]      q;
  logic             pready;
  logic             pslverr;
  logic             err_q;
  logic             irq;
  logic             sample_en;
  logic [CH_W-1:0]  mux_channel;
  logic [RES_W-1:0] dac_code;
  int               bad_count    = 0;
  int               total_checks = 0;
  localparam logic [11:0] A_MODE  = {IDX_MODE_SEL[9:0], 2'b00};
  localparam logic [11:0] A_PRIO  = {IDX_PRIO[9:0], 2'b00};
  localparam logic [11:0] A_RES0  = {IDX_RES0[9:0], 2'b00};
  localparam logic [11:0] A_PRES  = {IDX_PRES[9:0], 2'b00};
  localparam logic [11:0] A_CTRL  = {IDX_CTRL[9:0], 2'b00};
  localparam logic [11:0] A_MON   = {IDX_MON[9:0], 2'b00};
  localparam logic [11:0] A_CMPV  = {IDX_CMPV[9:0], 2'b00};
  localparam logic [11:0] A_ISTAT = {IDX_ISTAT[9:0], 2'b00};
  localparam logic [11:0] A_IMASK = {IDX_IMASK[9:0], 2'b00};

  adc_channel_select_priority_ctrl #(.ADDR_W(12), .SAMPLE(2), .SETTLE(5)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_idle(cpu_idle), .irq(irq), .comp_in(comp_in), .mux_channel(mux_channel),
    .dac_code(dac_code), .sample_en(sample_en));

  always #(CLK_NS / 2) pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  // Input level half an LSB above the code, so the result is exact
  function automatic logic [9:0] expv(input logic [3:0] c);
    return {c, 6'h13};
  endfunction
  always @(posedge pclk) comp_in <= {dac_code, 1'b0} < {expv(mux_channel), 1'b1};
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Request stands until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(q, e);
  endtask
  task automatic wait_stat(input int b);
    int n;
    n = 0;
    do begin
      rd(A_ISTAT);
      n++;
    end while (q[b] !== 1'b1 && n < 300);
    chk(32'(q[b]), 32'h1);
  endtask
  task automatic clr_res();
    for (int c = 0; c < 16; c++) rd(A_RES0 + 12'(4 * c));
  endtask
  task automatic res_chk(input int c, input logic st);
    rd(A_RES0 + 12'(4 * c));
    if (st) chk(q, {2'b10, 20'h0, expv(4'(c))});
    else chk(32'(q[31]), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(A_MODE, 32'h0);
    rdc(A_PRIO, 32'h0);
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_regs();
    wr(A_MODE, 32'hFFFF_FFFF);
    rdc(A_MODE, 32'h5F);
    wr(A_PRIO, 32'hFFFF_FFEF);
    rdc(A_PRIO, 32'h0F);
    pstrb <= 4'h0;
    wr(A_MODE, 32'h0);
    pstrb <= 4'hF;
    rdc(A_MODE, 32'h5F);
    rd(12'h010);
    chk({31'h0, err_q}, 32'h1);
    chk(q, 32'h0);
  endtask
  task automatic t_fixed();
    wr(A_IMASK, 32'h1);
    wr(A_MODE, 32'h49);
    clr_res();
    wr(A_CTRL, 32'h2);
    wait_stat(0);
    chk(32'(irq), 32'h1);
    wr(A_ISTAT, 32'h1);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    for (int c = 0; c < 16; c++) res_chk(c, c == 9);
    wr(A_IMASK, 32'h0);
    wr(A_CTRL, 32'h2);
    wait_stat(0);
    chk(32'(irq), 32'h0);
    wr(A_ISTAT, 32'h1);
  endtask
  task automatic t_scan(input logic wd);
    clr_res();
    wr(A_MODE, {25'h0, 1'b1, 1'b0, wd, 4'hE});
    wr(A_CTRL, 32'h3);
    wait_stat(0);
    wr(A_ISTAT, 32'h1);
    for (int c = 0; c < 16; c++) res_chk(c, c <= 14 && c >= (wd ? 8 : 12));
  endtask
  task automatic t_prio();
    int n;
    logic ok;
    n = 0;
    clr_res();
    wr(A_MODE, 32'h5F);
    wr(A_CTRL, 32'h3);
    repeat (90) @(posedge pclk);
    wr(A_PRIO, 32'h13);
    do begin
      @(negedge pclk);
      n++;
      ok = sample_en === 1'b1 && mux_channel === 4'h3;
    end while (!ok && n < 8);
    chk(32'(ok), 32'h1);
    rdc(A_PRIO, 32'h43);
    wait_stat(1);
    rdc(A_PRIO, 32'h83);
    rdc(A_PRES, {2'b10, 20'h0, expv(4'h3)});
    wait_stat(0);
    wr(A_ISTAT, 32'h3);
    for (int c = 0; c < 16; c++) res_chk(c, c >= 8);
  endtask
  task automatic t_idle();
    wr(A_MODE, 32'h02);
    wr(A_CTRL, 32'h2);
    // Freeze a conversion already under way
    repeat (20) @(posedge pclk);
    cpu_idle <= 1'b1;
    repeat (150) @(posedge pclk);
    rdc(A_ISTAT, 32'h0);
    cpu_idle <= 1'b0;
    wait_stat(0);
    wr(A_ISTAT, 32'h1);
    wr(A_MODE, 32'h42);
    wr(A_CTRL, 32'h2);
    cpu_idle <= 1'b1;
    repeat (150) @(posedge pclk);
    rdc(A_ISTAT, 32'h1);
    cpu_idle <= 1'b0;
    wr(A_ISTAT, 32'h1);
  endtask
  task automatic t_mon();
    wr(A_CMPV, 32'(expv(4'h9)) - 32'h1);
    wr(A_MON, 32'h13);
    wr(A_MODE, 32'h49);
    wr(A_CTRL, 32'h2);
    wait_stat(0);
    rdc(A_ISTAT, 32'h5);
    rdc(A_MON, 32'h93);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(CLK_NS * 40000);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_fixed();
    t_scan(1'b0);
    t_scan(1'b1);
    t_prio();
    t_idle();
    t_mon();
    tally_and_finish();
  end
endmodule

//--- sim/adc_ctrl_monitor.sv
/* Concurrent checks on the converter control block's top-level ports.
   Assumes APB on pclk with one wait state; bound to the top module below. */
`timescale 1ns/1ps
module adc_ctrl_monitor
  import adc_ctrl_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // System and front end
  input wire logic              cpu_idle,
  input wire logic              irq,
  input wire logic              comp_in,
  input wire logic [CH_W-1:0]   mux_channel,
  input wire logic [RES_W-1:0]  dac_code,
  input wire logic              sample_en
);
  localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'({IDX_MODE_SEL[9:0], 2'b00});
  localparam logic [ADDR_W-1:0] A_PRIO = ADDR_W'({IDX_PRIO[9:0], 2'b00});
  localparam logic [ADDR_W-1:0] A_RES0 = ADDR_W'({IDX_RES0[9:0], 2'b00});
  localparam logic [ADDR_W-1:0] A_PRES = ADDR_W'({IDX_PRES[9:0], 2'b00});
  logic rd_now;
  logic idle_q;
  assign rd_now = psel && penable && pready && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // Idle-operate bit as software last wrote it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      idle_q <= 1'b0;
    else if (psel && penable && pready && pwrite && pstrb[0] && paddr == A_MODE)
      idle_q <= pwdata[MS_IDLE_BIT];
  end
  ////////////////////////////////////////////////////////////////////////
  pready_wait_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (pready && paddr < ADDR_W'(12'hC00) |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && (paddr == A_MODE || paddr == A_PRIO) |-> !pslverr)
    else $error("mapped access refused");
  idle_zero_a: assert property (!pready |-> prdata == '0 && !pslverr)
    else $error("read data outside answer cycle");
  mode_rsvd_a: assert property (rd_now && paddr == A_MODE |-> prdata[31:7] == '0 && !prdata[5])
    else $error("mode register spare bits not zero");
  prio_rsvd_a: assert property (rd_now && paddr == A_PRIO |-> prdata[31:8] == '0 && prdata[5:4] == 2'b00)
    else $error("priority start bit read back nonzero");
  res_width_a: assert property (rd_now && (paddr[ADDR_W-1:6] == A_RES0[ADDR_W-1:6] || paddr == A_PRES)
    |-> prdata[29:10] == '0)
    else $error("result wider than ten bits");
  // Hold may take two cycles to reach the engine, hence six
  idle_freeze_a: assert property ((cpu_idle && !idle_q)[*6] |-> $stable(dac_code) && $stable(mux_channel))
    else $error("engine ran during idle");
endmodule

bind adc_channel_select_priority_ctrl adc_ctrl_monitor #(.ADDR_W(ADDR_W)) mon_i (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .irq(irq), .comp_in(comp_in),
  .mux_channel(mux_channel), .dac_code(dac_code), .sample_en(sample_en));

//--- src/adc_channel_select_priority_ctrl.sv
/*
  Converter control: channel selection, scan sequencing, priority conversion,
  result registers, monitor compare, interrupt status, APB slave.
  Assumes an APB master on pclk and an external comparator and sample switch.
*/
// The APB slave port was decided locally.
//
// Contract
// - Ten-bit results, sixteen selectable input channels.
// - Priority request interrupts normal conversion first.
// - Monitor compares chosen result against compare value.
// - Per-channel results; priority result kept separately.
// - Idle bit: 0 stops in idle, 1 runs.
// - Fixed mode converts the selected channel only.
// - Width 0 scans 4-group start to selected.
// - Width 1 scans 8-group start to selected.
// - Priority busy flag reads 1 while converting.
// - Priority start bit writes one, reads zero.
// - Priority channel field selects channels 0-15.
`timescale 1ns/1ps
module adc_channel_select_priority_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SAMPLE = SAMPLE_CYC,
  parameter int SETTLE = SETTLE_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System
  input  wire logic              cpu_idle,
  output logic                   irq,
  // Analog front end
  input  wire logic              comp_in,
  output logic [CH_W-1:0]        mux_channel,
  output logic [RES_W-1:0]       dac_code,
  output logic                   sample_en
);
  localparam int WA_W = ADDR_W - 2;

  conv_if cv ();

  // Registers
  logic [7:0]           mode_sel;
  logic [CH_W-1:0]      prio_ch;
  logic                 prio_end;
  logic                 scan_en;
  logic                 repeat_en;
  logic                 run;
  logic                 mon_en;
  logic [4:0]           mon_sel;
  logic                 mon_gt;
  logic [RES_W-1:0]     cmp_val;
  logic [IRQ_W-1:0]     istat;
  logic [IRQ_W-1:0]     imask;
  logic [RES_W-1:0]     res      [NCH];
  logic [NCH-1:0]       stored;
  logic [NCH-1:0]       overrun;
  logic [RES_W-1:0]     pres;
  logic                 pres_stored;
  logic                 pres_ovr;

  // Sequencer
  logic [CH_W-1:0]      cur_ch;
  logic                 norm_active;
  logic                 prio_active;
  logic                 prio_pend;
  logic                 freeze;
  logic                 comp_meta;
  logic                 comp_sync;

  // Bus decode
  logic [WA_W-1:0]      wa;
  logic                 acc_done;
  logic                 wr;
  logic                 rd;
  logic [WA_W-1:0]      res_rel;
  logic                 res_hit;
  logic [31:0]          next_prdata;
  logic                 next_err;

  // Events
  logic                 store_norm;
  logic                 store_prio;
  logic                 seq_end;
  logic                 mon_hit;
  logic [CH_W-1:0]      first_ch;
  logic                 at_last;
  logic [IRQ_W-1:0]     ev;
  logic [IRQ_W-1:0]     next_istat;

  function automatic logic is_reg(input logic [WA_W-1:0] a, input logic [31:0] idx);
    is_reg = (a == idx[WA_W-1:0]);
  endfunction

  function automatic logic [CH_W-1:0] scan_first(input logic [7:0] ms, input logic scan);
    if (!scan)
      scan_first = ms[CH_W-1:0];
    else if (ms[MS_WIDTH_BIT])
      scan_first = {ms[CH_W-1], 3'h0};
    else
      scan_first = {ms[CH_W-1:CH_W-2], 2'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Comparator input crosses in from the analog side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
    end
  end

  adc_conv_engine #(
    .SAMPLE (SAMPLE),
    .SETTLE (SETTLE)
  ) u_engine (
    .pclk        (pclk),
    .presetn     (presetn),
    .cv          (cv.eng),
    .comp_sync   (comp_sync),
    .mux_channel (mux_channel),
    .dac_code    (dac_code),
    .sample_en   (sample_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state so that read data comes from a flop
  assign wa       = paddr[ADDR_W-1:2];
  assign acc_done = psel & penable & pready;
  assign wr       = acc_done & pwrite & ~pslverr & pstrb[0];
  assign rd       = acc_done & ~pwrite & ~pslverr;
  assign res_rel  = wa - IDX_RES0[WA_W-1:0];
  assign res_hit  = (res_rel < WA_W'(NCH));

  always_comb begin
    next_prdata = '0;
    next_err    = 1'b0;
    if (is_reg(wa, IDX_MODE_SEL)) begin
      next_prdata[7:0] = mode_sel;
    end else if (is_reg(wa, IDX_PRIO)) begin
      next_prdata[PR_END_BIT]    = prio_end;
      next_prdata[PR_BUSY_BIT]   = prio_pend | prio_active;
      next_prdata[CH_W-1:0]      = prio_ch;
    end else if (res_hit) begin
      next_prdata[RES_W-1:0]     = res[res_rel[CH_W-1:0]];
      next_prdata[RES_STORED_BIT] = stored[res_rel[CH_W-1:0]];
      next_prdata[RES_OVR_BIT]   = overrun[res_rel[CH_W-1:0]];
    end else if (is_reg(wa, IDX_PRES)) begin
      next_prdata[RES_W-1:0]     = pres;
      next_prdata[RES_STORED_BIT] = pres_stored;
      next_prdata[RES_OVR_BIT]   = pres_ovr;
    end else if (is_reg(wa, IDX_CTRL)) begin
      next_prdata[CTRL_SCAN_BIT] = scan_en;
      next_prdata[CTRL_REP_BIT]  = repeat_en;
      next_prdata[CTRL_RUN_BIT]  = run;
    end else if (is_reg(wa, IDX_MON)) begin
      next_prdata[MON_EN_BIT]    = mon_en;
      next_prdata[MON_SEL_LSB+:5] = mon_sel;
      next_prdata[MON_GT_BIT]    = mon_gt;
    end else if (is_reg(wa, IDX_CMPV)) begin
      next_prdata[RES_W-1:0]     = cmp_val;
    end else if (is_reg(wa, IDX_ISTAT)) begin
      next_prdata[IRQ_W-1:0]     = istat;
    end else if (is_reg(wa, IDX_IMASK)) begin
      next_prdata[IRQ_W-1:0]     = imask;
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & next_err;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sel  <= MODE_SEL_RST;
      prio_ch   <= PRIO_RST[CH_W-1:0];
      scan_en   <= 1'b0;
      repeat_en <= 1'b0;
      mon_en    <= 1'b0;
      mon_sel   <= '0;
      cmp_val   <= '0;
      imask     <= '0;
    end else if (wr) begin
      if (is_reg(wa, IDX_MODE_SEL))
        mode_sel <= pwdata[7:0] & 8'h5F;
      if (is_reg(wa, IDX_PRIO))
        prio_ch <= pwdata[CH_W-1:0];
      if (is_reg(wa, IDX_CTRL)) begin
        scan_en   <= pwdata[CTRL_SCAN_BIT];
        repeat_en <= pwdata[CTRL_REP_BIT];
      end
      if (is_reg(wa, IDX_MON)) begin
        mon_en  <= pwdata[MON_EN_BIT];
        mon_sel <= pwdata[MON_SEL_LSB+:5];
      end
      if (is_reg(wa, IDX_CMPV) && pstrb[1])
        cmp_val <= pwdata[RES_W-1:0];
      if (is_reg(wa, IDX_IMASK))
        imask <= pwdata[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: priority work always goes ahead of the scan
  assign first_ch   = scan_first(mode_sel, scan_en);
  assign at_last    = (cur_ch >= mode_sel[CH_W-1:0]);
  assign store_norm = cv.done & norm_active;
  assign store_prio = cv.done & prio_active;
  assign seq_end    = store_norm & at_last;
  assign freeze     = cpu_idle & ~mode_sel[MS_IDLE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run         <= 1'b0;
      cur_ch      <= '0;
      norm_active <= 1'b0;
      prio_active <= 1'b0;
      prio_pend   <= 1'b0;
      cv.start    <= 1'b0;
      cv.abort    <= 1'b0;
      cv.chan     <= '0;
      cv.hold     <= 1'b0;
    end else begin
      cv.start <= 1'b0;
      cv.abort <= 1'b0;
      // Converter freezes in processor idle unless told to keep going
      cv.hold  <= freeze;
      if (wr && is_reg(wa, IDX_PRIO) && pwdata[PR_START_BIT])
        prio_pend <= 1'b1;
      if (wr && is_reg(wa, IDX_CTRL) && pwdata[CTRL_START_BIT]) begin
        run    <= 1'b1;
        // Scan enable written with the start takes effect at once
        cur_ch <= scan_first(mode_sel, pwdata[CTRL_SCAN_BIT]);
      end
      if (store_prio)
        prio_active <= 1'b0;
      if (store_norm) begin
        norm_active <= 1'b0;
        if (at_last) begin
          cur_ch <= first_ch;
          if (!repeat_en)
            run <= 1'b0;
        end else begin
          cur_ch <= cur_ch + 1'b1;
        end
      end else if (prio_pend && norm_active) begin
        // Aborted channel is simply redone afterwards
        cv.abort    <= 1'b1;
        norm_active <= 1'b0;
      end else if (prio_pend && !prio_active && !norm_active && !cv.busy && !freeze) begin
        cv.start    <= 1'b1;
        cv.chan     <= prio_ch;
        prio_active <= 1'b1;
        prio_pend   <= 1'b0;
      end else if (run && !prio_pend && !prio_active && !norm_active && !cv.busy && !freeze) begin
        cv.start    <= 1'b1;
        cv.chan     <= scan_en ? cur_ch : mode_sel[CH_W-1:0];
        norm_active <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result storage; a store in the same cycle as a read keeps its flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++)
        res[i] <= '0;
      stored      <= '0;
      overrun     <= '0;
      pres        <= '0;
      pres_stored <= 1'b0;
      pres_ovr    <= 1'b0;
    end else begin
      if (rd && res_hit) begin
        stored[res_rel[CH_W-1:0]]  <= 1'b0;
        overrun[res_rel[CH_W-1:0]] <= 1'b0;
      end
      if (rd && is_reg(wa, IDX_PRES)) begin
        pres_stored <= 1'b0;
        pres_ovr    <= 1'b0;
      end
      if (store_norm) begin
        res[cv.chan]     <= cv.result;
        stored[cv.chan]  <= 1'b1;
        overrun[cv.chan] <= stored[cv.chan];
      end
      if (store_prio) begin
        pres        <= cv.result;
        pres_stored <= 1'b1;
        pres_ovr    <= pres_stored;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority end flag, cleared by the next priority start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prio_end <= 1'b0;
    else if (store_prio)
      prio_end <= 1'b1;
    else if (wr && is_reg(wa, IDX_PRIO) && pwdata[PR_START_BIT])
      prio_end <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: checks the chosen register each time it is rewritten
  assign mon_hit = mon_en & (mon_sel[4] ? store_prio : (store_norm & (cv.chan == mon_sel[CH_W-1:0])));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mon_gt <= 1'b0;
    else if (mon_hit)
      mon_gt <= (cv.result > cmp_val);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set wins
  assign ev[IRQ_NORM] = seq_end;
  assign ev[IRQ_PRIO] = store_prio;
  assign ev[IRQ_MON]  = mon_hit & (cv.result > cmp_val);
  assign next_istat   = (istat & ~((wr && is_reg(wa, IDX_ISTAT)) ? pwdata[IRQ_W-1:0] : '0)) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat <= '0;
      irq   <= 1'b0;
    end else begin
      istat <= next_istat;
      irq   <= |(next_istat & imask);
    end
  end
endmodule

//--- src/adc_conv_engine.sv
/*
  Successive approximation engine: samples one channel, then resolves one bit per step.
  Assumes comp_sync is already synchronised and high when the input is above dac_code.
*/
`timescale 1ns/1ps
module adc_conv_engine
  import adc_ctrl_pkg::*;
#(
  parameter int SAMPLE = SAMPLE_CYC,
  parameter int SETTLE = SETTLE_CYC
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control side
  conv_if.eng                   cv,
  // Analog front end
  input  wire logic             comp_sync,
  output logic [CH_W-1:0]       mux_channel,
  output logic [RES_W-1:0]      dac_code,
  output logic                  sample_en
);
  eng_state_t        state;
  logic [CNT_W-1:0]  cnt;
  logic [3:0]        bitpos;
  logic [RES_W-1:0]  acc;
  logic [RES_W-1:0]  kept;

  function automatic logic [RES_W-1:0] trial_bit(input logic [3:0] pos);
    trial_bit = RES_W'(1) << pos;
  endfunction

  // Trial bit stays only if the input lies above it
  assign kept = comp_sync ? dac_code : acc;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ENG_IDLE;
      cnt         <= '0;
      bitpos      <= '0;
      acc         <= '0;
      dac_code    <= '0;
      mux_channel <= '0;
      sample_en   <= 1'b0;
      cv.busy     <= 1'b0;
      cv.done     <= 1'b0;
      cv.result   <= '0;
    end else begin
      cv.done <= 1'b0;
      if (cv.abort) begin
        state     <= ENG_IDLE;
        sample_en <= 1'b0;
        cv.busy   <= 1'b0;
      end else if (!cv.hold) begin
        unique case (state)
          ENG_IDLE: begin
            if (cv.start) begin
              mux_channel <= cv.chan;
              sample_en   <= 1'b1;
              cnt         <= CNT_W'(SAMPLE - 1);
              cv.busy     <= 1'b1;
              state       <= ENG_SAMPLE;
            end
          end
          ENG_SAMPLE: begin
            if (cnt == '0) begin
              sample_en <= 1'b0;
              bitpos    <= 4'(RES_W - 1);
              acc       <= '0;
              dac_code  <= trial_bit(4'(RES_W - 1));
              cnt       <= CNT_W'(SETTLE - 1);
              state     <= ENG_BIT;
            end else begin
              cnt <= cnt - 1'b1;
            end
          end
          ENG_BIT: begin
            if (cnt != '0) begin
              cnt <= cnt - 1'b1;
            end else if (bitpos == '0) begin
              cv.result <= kept;
              cv.done   <= 1'b1;
              cv.busy   <= 1'b0;
              state     <= ENG_IDLE;
            end else begin
              acc      <= kept;
              dac_code <= kept | trial_bit(bitpos - 1'b1);
              bitpos   <= bitpos - 1'b1;
              cnt      <= CNT_W'(SETTLE - 1);
            end
          end
        endcase
      end
    end
  end
endmodule
